// >>> hdl/mtc_pkg.sv
// constants for the machine trap and identity register set
`default_nettype none
package mtc_pkg;
  localparam logic [11:0] ADDR_INT_ENABLE  = 12'h304;
  localparam logic [11:0] ADDR_TRAP_CAUSE  = 12'h342;
  localparam logic [11:0] ADDR_INT_PENDING = 12'h344;
  localparam logic [11:0] ADDR_HART_ID     = 12'hf14;
  localparam logic [11:0] ADDR_SEC_CAUSE   = 12'h7ff;

  localparam int BIT_SOFT = 3;
  localparam int BIT_TIMER = 7;
  localparam int BIT_EXT = 11;
  localparam int BIT_CORR = 30;
  localparam int THREAD_W = 4;
  localparam logic [31:0] INT_MASK = 32'h4000_0888;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [3:0] THREAD_ID = 4'h0;

  // legal causes
  localparam logic [31:0] CAUSE_NMI_PIN   = 32'h0000_0000;
  localparam logic [31:0] CAUSE_IFETCH    = 32'h0000_0001;
  localparam logic [31:0] CAUSE_ILLEGAL   = 32'h0000_0002;
  localparam logic [31:0] CAUSE_BREAK     = 32'h0000_0003;
  localparam logic [31:0] CAUSE_LD_MIS    = 32'h0000_0004;
  localparam logic [31:0] CAUSE_LD_ACC    = 32'h0000_0005;
  localparam logic [31:0] CAUSE_ST_MIS    = 32'h0000_0006;
  localparam logic [31:0] CAUSE_ST_ACC    = 32'h0000_0007;
  localparam logic [31:0] CAUSE_ECALL     = 32'h0000_000b;
  localparam logic [31:0] CAUSE_INT_SOFT  = 32'h8000_0003;
  localparam logic [31:0] CAUSE_INT_TIMER = 32'h8000_0007;
  localparam logic [31:0] CAUSE_INT_EXT   = 32'h8000_000b;
  localparam logic [31:0] CAUSE_INT_CORR  = 32'h8000_001e;
  localparam logic [31:0] CAUSE_NMI_ST    = 32'hf000_0000;
  localparam logic [31:0] CAUSE_NMI_LD    = 32'hf000_0001;
  localparam logic [31:0] CAUSE_NMI_ECC   = 32'hf000_1000;
  localparam logic [31:0] CAUSE_NMI_DCCM  = 32'hf000_1001;
  localparam logic [31:0] CAUSE_NMI_VEC   = 32'hf000_1002;
  localparam logic [31:0] CAUSE_RESET     = CAUSE_NMI_PIN;
  localparam int SEC_W = 4;
endpackage
`default_nettype wire

// >>> hdl/mtc_cause_legal.sv
// checks a 32-bit value against the legal trap cause encodings
`default_nettype none
module mtc_cause_legal (
  // value under test
  input  wire logic [31:0] value,
  // verdict
  output logic             legal
);
  import mtc_pkg::*;
  always_comb begin
    unique case (value)
      CAUSE_NMI_PIN, CAUSE_IFETCH, CAUSE_ILLEGAL, CAUSE_BREAK, CAUSE_LD_MIS, CAUSE_LD_ACC,
      CAUSE_ST_MIS, CAUSE_ST_ACC, CAUSE_ECALL, CAUSE_INT_SOFT, CAUSE_INT_TIMER, CAUSE_INT_EXT,
      CAUSE_INT_CORR, CAUSE_NMI_ST, CAUSE_NMI_LD, CAUSE_NMI_ECC, CAUSE_NMI_DCCM,
      CAUSE_NMI_VEC: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/mtc_trap_csr.sv
// machine trap enable, pending, cause and hart identity registers
`default_nettype none
module mtc_trap_csr (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // csr access
  input  wire logic                          csr_rd,
  input  wire logic                          csr_wr,
  input  wire logic [11:0]                   csr_addr,
  input  wire logic [31:0]                   csr_wdata,
  output logic      [31:0]                   csr_rdata,
  output logic                               csr_hit,
  // interrupt sources
  input  wire logic                          irq_soft,
  input  wire logic                          irq_timer,
  input  wire logic                          irq_ext,
  input  wire logic                          irq_corr,
  // trap capture from the pipeline
  input  wire logic                          trap_take,
  input  wire logic [31:0]                   trap_cause_in,
  input  wire logic [mtc_pkg::SEC_W-1:0]     trap_detail,
  // hardwired core identity
  input  wire logic [31:mtc_pkg::THREAD_W]   core_identifier_bus,
  // register views for the trap logic
  output logic      [31:0]                   int_enable_q,
  output logic      [31:0]                   int_pending_q,
  output logic      [31:0]                   trap_cause_q
);
  import mtc_pkg::*;

  typedef struct packed {
    logic [31:0]      enable;
    logic [31:0]      pending;
    logic [31:0]      cause;
    logic [SEC_W-1:0] sec_cause;
    logic [31:0]      rdata;
    logic             hit;
  } mtc_state_s;

  mtc_state_s st;
  mtc_state_s next_st;
  logic       wr_legal;
  logic       trap_legal;
  logic [31:0] src_vec;

  mtc_cause_legal u_wr_chk (
    .value (csr_wdata),
    .legal (wr_legal)
  );

  mtc_cause_legal u_trap_chk (
    .value (trap_cause_in),
    .legal (trap_legal)
  );

  always_comb begin
    src_vec = ZERO32;
    src_vec[BIT_SOFT]  = irq_soft;
    src_vec[BIT_TIMER] = irq_timer;
    src_vec[BIT_EXT]   = irq_ext;
    src_vec[BIT_CORR]  = irq_corr;
  end

  always_comb begin
    next_st = st;
    // pending mirrors live sources, masked to implemented bits
    next_st.pending = src_vec & INT_MASK;
    // software writes target enable, not pending; pending ignores them
    if (csr_wr && csr_addr == ADDR_INT_ENABLE) begin
      next_st.enable = csr_wdata & INT_MASK;
    end
    // illegal writes are dropped so the field never reads back reserved codes
    if (csr_wr && csr_addr == ADDR_TRAP_CAUSE && wr_legal) begin
      next_st.cause = csr_wdata;
    end
    if (csr_wr && csr_addr == ADDR_SEC_CAUSE) begin
      next_st.sec_cause = csr_wdata[SEC_W-1:0];
    end
    // hardware capture wins over a same-cycle software write
    if (trap_take && trap_legal) begin
      next_st.cause     = trap_cause_in;
      next_st.sec_cause = trap_detail;
    end
    next_st.hit   = 1'b0;
    next_st.rdata = ZERO32;
    if (csr_rd) begin
      unique case (csr_addr)
        ADDR_INT_ENABLE: begin
          next_st.hit   = 1'b1;
          next_st.rdata = st.enable & INT_MASK;
        end
        ADDR_INT_PENDING: begin
          next_st.hit   = 1'b1;
          next_st.rdata = st.pending & INT_MASK;
        end
        ADDR_TRAP_CAUSE: begin
          next_st.hit   = 1'b1;
          next_st.rdata = st.cause;
        end
        ADDR_SEC_CAUSE: begin
          next_st.hit   = 1'b1;
          next_st.rdata = {{(32-SEC_W){1'b0}}, st.sec_cause};
        end
        ADDR_HART_ID: begin
          next_st.hit   = 1'b1;
          next_st.rdata = {core_identifier_bus, THREAD_ID};
        end
        default: begin
          next_st.hit   = 1'b0;
          next_st.rdata = ZERO32;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{enable: ZERO32, pending: ZERO32, cause: CAUSE_RESET,
              sec_cause: '0, rdata: ZERO32, hit: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign csr_rdata     = st.rdata;
  assign csr_hit       = st.hit;
  assign int_enable_q  = st.enable;
  assign int_pending_q = st.pending;
  assign trap_cause_q  = st.cause;
endmodule
`default_nettype wire

// >>> sim/mtc_sva.sv
// assertions on the trap register ports
`default_nettype none
module mtc_sva import mtc_pkg::*; (
  // csr side
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        csr_rd,
  input wire logic        csr_wr,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_rdata,
  input wire logic        csr_hit,
  // trap side
  input wire logic        trap_take,
  input wire logic [31:4] core_identifier_bus,
  input wire logic [31:0] int_enable_q,
  input wire logic [31:0] trap_cause_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rsv; (int_enable_q&~INT_MASK)==ZERO32; endproperty
  a_rsv: assert property(p_rsv) else $error("enable");
  property p_cz; trap_cause_q[27:13]==15'h0000; endproperty
  a_cz: assert property(p_cz) else $error("cause");
  property p_exc; !trap_cause_q[31]|->trap_cause_q[30:4]==27'h0000000; endproperty
  a_exc: assert property(p_exc) else $error("code");
  property p_hid; csr_rd&&csr_addr==ADDR_HART_ID|=>csr_rdata=={core_identifier_bus,THREAD_ID}; endproperty
  a_hid: assert property(p_hid) else $error("hart");
  property p_unm; csr_rd&&csr_addr==12'h000|=>!csr_hit&&csr_rdata==ZERO32; endproperty
  a_unm: assert property(p_unm) else $error("unmapped");
  property p_rdc; csr_rd&&csr_addr==ADDR_TRAP_CAUSE|=>csr_hit&&csr_rdata==$past(trap_cause_q); endproperty
  a_rdc: assert property(p_rdc) else $error("read");
  property p_stb; !trap_take&&!csr_wr|=>$stable(trap_cause_q); endproperty
  a_stb: assert property(p_stb) else $error("moved");
  property p_rz; !csr_rd|=>!csr_hit&&csr_rdata==ZERO32; endproperty
  a_rz: assert property(p_rz) else $error("idle");
  c_trp: cover property(trap_take);
  c_rd: cover property(csr_rd);
  c_wr: cover property(csr_wr);
endmodule
`default_nettype wire

// >>> sim/mtc_soc.sv
// soc model: irq levels and core_identifier_bus
`default_nettype none
module mtc_soc #(parameter logic [31:4] CID = 28'h0000123) (  // id arbitrary
  // bench side
  input  wire logic [3:0] req,
  // core side
  output logic            irq_soft,
  output logic            irq_timer,
  output logic            irq_ext,
  output logic            irq_corr,
  output logic [31:4]     core_identifier_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  assign {irq_corr,irq_ext,irq_timer,irq_soft} = req;
  // fixed for the whole run, unique per core
  assign core_identifier_bus = CID;
endmodule
`default_nettype wire

// >>> sim/tb.sv
// bench for the trap register set
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mtc_pkg::*;
  localparam logic [31:4] CID = 28'h0000123;
  logic clk=1'h0,rstn=1'h0,csr_rd=1'h0,csr_wr=1'h0,trap_take=1'h0,csr_hit,irq_soft,irq_timer,irq_ext,irq_corr;
  logic [3:0] req=4'h0,trap_detail=4'ha;
  logic [11:0] csr_addr=12'h000;
  logic [31:0] csr_wdata=ZERO32,trap_cause_in=ZERO32,csr_rdata,int_enable_q,int_pending_q,trap_cause_q;
  logic [31:4] core_identifier_bus;
  int error_cnt=0,comparisons=0;
  mtc_trap_csr u_dut(.*);
  mtc_soc #(.CID(CID)) u_soc(.*);
  initial forever #5 clk=~clk;
  task automatic chk(input logic [32:0] got,exp);
    comparisons++;
    if (got!==exp) begin
      error_cnt++;
      $display("mismatch %0t: %h not %h",$time,got,exp);
    end
  endtask
  task automatic put(input logic w,t,input logic [11:0] a,input logic [31:0] d);
    @(posedge clk) #1 {csr_wr,trap_take,csr_addr,csr_wdata,trap_cause_in}={w,t,a,d,d};
    @(posedge clk) #1 {csr_wr,trap_take}=2'h0;
  endtask
  task automatic rd(input logic [11:0] a,input logic [31:0] e);
    @(posedge clk) #1 {csr_rd,csr_addr}={1'h1,a};
    @(posedge clk) #1 csr_rd=1'h0;
    chk({csr_hit,csr_rdata},{a!=12'h000,e});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d",comparisons,error_cnt);
    if (error_cnt==0&&comparisons>0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] cl [18]='{32'h1,32'h2,32'h3,32'h4,32'h5,32'h6,32'h7,32'hb,32'h80000003,32'h80000007,
      32'h8000000b,32'h8000001e,32'hf0000000,32'hf0000001,32'hf0001000,32'hf0001001,32'hf0001002,32'h0};
    repeat (10) @(posedge clk);
    #1 rstn=1'h1;
    rd(ADDR_INT_ENABLE,ZERO32);
    rd(ADDR_INT_PENDING,ZERO32);
    put(1'h1,1'h0,ADDR_INT_ENABLE,32'hffffffff);
    rd(ADDR_INT_ENABLE,INT_MASK);
    put(1'h1,1'h0,ADDR_INT_ENABLE,ZERO32);
    req=4'hf;
    put(1'h1,1'h0,ADDR_INT_PENDING,ZERO32);
    put(1'h1,1'h0,ADDR_HART_ID,ZERO32);
    rd(ADDR_INT_PENDING,INT_MASK);
    rd(ADDR_HART_ID,{CID,THREAD_ID});
    rd(12'h000,ZERO32);
    $display("register test done");
    foreach (cl[i]) begin
      put(1'h0,1'h1,12'h000,cl[i]);
      rd(ADDR_TRAP_CAUSE,cl[i]);
    end
    rd(ADDR_SEC_CAUSE,32'ha);
    put(1'h1,1'h0,ADDR_TRAP_CAUSE,32'h80000007);
    rd(ADDR_TRAP_CAUSE,CAUSE_INT_TIMER);
    put(1'h0,1'h1,12'h000,32'h80000001);
    put(1'h1,1'h0,ADDR_TRAP_CAUSE,32'hc);
    rd(ADDR_TRAP_CAUSE,CAUSE_INT_TIMER);
    $display("cause test done");
    summarize();
  end
endmodule
bind mtc_trap_csr mtc_sva u_sva(.*);
`default_nettype wire
